// *** logic/pmc_pkg.sv ***
// Shared constants and types for the panel matrix controller
//
// Behaviour
// - Quadrature encoder gives step pulse and direction
// - Four-bit core sensing groups A and B
// - Decoded strobes scan matrix; pair names function
// - Strobe zero on A0 steps frequency
// - Strobe zero on A1 means step upward
// - Strobe two selects memory channels one-five
// - Strobe three on A0 selects second TUNED_FREQUENCY_REGISTER
// - Strobe three on A1 memory read, overrides TUNED_FREQUENCY_REGISTER
// - Strobe four decodes 5/10/15/25 kHz steps
// - Strobe five A0/A1 gives plus/minus offset
// - Strobe five A3 reverses receive and transmit
// - Out-of-band transmit falls back to receive
// - Strobe six A0 with priority edits offset
// - Programmed scan between channels one and two
// - Strobe seven A1 scans memories and VFOs
// - Strobe seven A3 writes memory or TUNED_FREQUENCY_REGISTER
// - Strobe eight A0 power on, else standby
// - Strobe zero B bits choose band limits
// - Strobe six on B1,B2 presets 600 kHz
// - Multiplexed display, point on MHz digit
// - Power-up reads mode then presets storage
// - Time-shared BCD loads divider with strobe
package pmc_pkg;

  // ****************
  // Timing
  // ****************
  localparam int CLK_NS           = 25;
  localparam int STROBE_DWELL_NS  = 400;
  localparam int STROBE_DWELL_CYC = (STROBE_DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DIGIT_DWELL_NS   = 1000;
  localparam int DIGIT_DWELL_CYC  = (DIGIT_DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATCH_AT_CYC     = DIGIT_DWELL_CYC / 2;
  localparam int SCAN_PERIOD_MS   = 100;
  localparam int SCAN_PERIOD_CYC  = SCAN_PERIOD_MS * 1000000 / CLK_NS;
  localparam int NUM_STROBES      = 9;
  localparam int NUM_MEM          = 5;

  // ****************
  // Frequencies, in 5 kHz units
  // ****************
  localparam int FW = 15;
  localparam logic [FW-1:0] F_BASE     = 15'h6D60; // 140.000 MHz
  localparam logic [FW-1:0] F_NAR_LO   = 15'h7080; // 144.000 MHz
  localparam logic [FW-1:0] F_NAR_HI   = 15'h720F; // 145.995 MHz
  localparam logic [FW-1:0] F_WIDE_LO  = 15'h7058; // 143.800 MHz
  localparam logic [FW-1:0] F_WIDE_HI  = 15'h73C7; // 148.195 MHz
  localparam logic [FW-1:0] OFFSET_600 = 15'h0078; // 600 kHz
  localparam logic [9:0]    N_BIAS     = 10'h06B;  // divide number over output
  localparam logic [2:0]    STEP_5K    = 3'h1;
  localparam logic [2:0]    STEP_10K   = 3'h2;
  localparam logic [2:0]    STEP_15K   = 3'h3;
  localparam logic [2:0]    STEP_25K   = 3'h5;

  // ****************
  // Register map
  // ****************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RXF    = 8'h08;
  localparam logic [7:0] REG_TXF    = 8'h0C;
  localparam logic [7:0] REG_OFFSET = 8'h10;
  localparam logic [7:0] REG_MODE   = 8'h14;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] CTRL_RST   = 2'h0;

  typedef struct packed {
    logic [2:0] chan;
    logic       vfo_b;
    logic       mem_read;
    logic [2:0] step;
    logic       dup_plus;
    logic       dup_minus;
    logic       reverse;
    logic       offset_edit;
    logic       prog_scan;
    logic       mem_scan;
    logic       mem_write;
    logic       power_on;
    logic       band_wide;
  } pmc_func_t;

  typedef enum logic [1:0] {ST_WAIT_MODE, ST_PRESET, ST_RUN} pmc_state_t;

endpackage

// *** logic/pmc_top.sv ***
// Panel matrix controller: encoder, switch matrix, display and divider loading
`timescale 1ns/10ps
`default_nettype none
module pmc_top #(
  parameter int SCAN_PERIOD = pmc_pkg::SCAN_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Panel pins
  input  wire logic        enc_phase_a,
  input  wire logic        enc_phase_b,
  input  wire logic        scan_button_n,
  input  wire logic        priority_button_n,
  input  wire logic        ptt_n,
  input  wire logic [3:0]  sense_a,
  input  wire logic [3:0]  sense_b,
  output logic [8:0]       strobe,
  // Display and synthesizer
  output logic [3:0]       bcd_out,
  output logic [3:0]       digit_select,
  output logic             decimal_point,
  output logic [3:0]       latch_position,
  output logic             synth_latch_strobe
);
  import pmc_pkg::*;

  // ****************
  // Pin synchronisers
  // ****************
  localparam int NP = 13;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_r;
  logic [NP-1:0] s2_r;
  logic [NP-1:0] s3_r;
  logic [NP-1:0] pin_r;
  assign pin_raw = {ptt_n, priority_button_n, scan_button_n, enc_phase_b, enc_phase_a,
                    sense_b, sense_a};

  always_ff @(posedge aclk) begin
    s1_r <= pin_raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!aresetn) begin
      // Buttons idle high, encoder phases idle low: no false edge after reset
      pin_r <= {3'h7, 2'h0, 8'h00};
    end else begin
      // A change counts only once two late stages agree
      for (int i = 0; i < NP; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic [3:0] sa;
  logic [3:0] sb;
  logic       enc_a;
  logic       enc_b;
  logic       scan_btn;
  logic       prio_btn;
  logic       ptt;
  assign sa       = pin_r[3:0];
  assign sb       = pin_r[7:4];
  assign enc_a    = pin_r[8];
  assign enc_b    = pin_r[9];
  assign scan_btn = ~pin_r[10];
  assign prio_btn = ~pin_r[11];
  assign ptt      = ~pin_r[12];

  // ****************
  // Strobe sequencer
  // ****************
  logic [3:0] stb_idx_r;
  logic [4:0] dwell_r;
  logic       sample;
  assign sample = (dwell_r == 5'(STROBE_DWELL_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stb_idx_r <= 4'h0;
      dwell_r   <= 5'h00;
      strobe    <= 9'h001;
    end else if (sample) begin
      dwell_r <= 5'h00;
      // Cycles forever so every function refreshes once a pass
      if (stb_idx_r == 4'(NUM_STROBES - 1)) begin
        stb_idx_r <= 4'h0;
        strobe    <= 9'h001;
      end else begin
        stb_idx_r <= stb_idx_r + 4'h1;
        strobe    <= {strobe[7:0], 1'b0};
      end
    end else begin
      dwell_r <= dwell_r + 5'h01;
    end
  end

  // ****************
  // Encoder and scan pulses
  // ****************
  logic enc_a_d_r;
  logic enc_pend_r;
  logic enc_up_r;
  logic scan_active_r;
  logic scan_pend_r;
  logic blink_r;
  logic [31:0] scan_cnt_r;
  logic consume;
  logic scan_tick;
  assign consume   = sample && stb_idx_r == 4'h0;
  assign scan_tick = scan_active_r && scan_cnt_r == 32'(SCAN_PERIOD - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_a_d_r  <= 1'b0;
      enc_pend_r <= 1'b0;
      enc_up_r   <= 1'b0;
    end else begin
      enc_a_d_r <= enc_a;
      // Rising phase A marks a detent; phase B gives direction
      if (enc_a && !enc_a_d_r) begin
        enc_pend_r <= 1'b1;
        enc_up_r   <= enc_b;
      end else if (consume) begin
        enc_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !scan_active_r) begin
      scan_cnt_r  <= 32'h0;
      scan_pend_r <= 1'b0;
      blink_r     <= 1'b0;
    end else begin
      scan_cnt_r <= scan_tick ? 32'h0 : scan_cnt_r + 32'h1;
      if (scan_tick) begin
        scan_pend_r <= 1'b1;
        blink_r     <= ~blink_r;
      end else if (consume) begin
        scan_pend_r <= 1'b0;
      end
    end
  end

  // Pulses merge into the matrix as the A0 and A1 returns
  logic a0_eff;
  logic a1_eff;
  assign a0_eff = sa[0] | enc_pend_r | scan_pend_r;
  assign a1_eff = sa[1] | (enc_pend_r & enc_up_r);

  // ****************
  // Matrix decode
  // ****************
  pmc_func_t  fn_r;
  pmc_state_t state_r;
  logic       dup600_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fn_r     <= '0;
      dup600_r <= 1'b0;
    end else if (sample) begin
      case (stb_idx_r)
        4'h0: begin
          if (sb[2]) begin
            fn_r.band_wide <= 1'b0;
          end else if (sb[0] && sb[3]) begin
            fn_r.band_wide <= 1'b1;
          end
        end
        4'h2: begin
          if (sa[0] && sa[1]) begin
            fn_r.chan <= 3'h5;
          end else if (sa[0]) begin
            fn_r.chan <= 3'h1;
          end else if (sa[1]) begin
            fn_r.chan <= 3'h2;
          end else if (sa[2]) begin
            fn_r.chan <= 3'h3;
          end else if (sa[3]) begin
            fn_r.chan <= 3'h4;
          end else begin
            fn_r.chan <= 3'h0;
          end
        end
        4'h3: begin
          fn_r.vfo_b    <= sa[0];
          fn_r.mem_read <= sa[1];
        end
        4'h4: begin
          if (sa[0] && sa[3]) begin
            fn_r.step <= STEP_25K;
          end else if (sa[0] && sa[2]) begin
            fn_r.step <= STEP_15K;
          end else if (sa[3]) begin
            fn_r.step <= STEP_10K;
          end else begin
            fn_r.step <= STEP_5K;
          end
        end
        4'h5: begin
          fn_r.dup_plus  <= sa[0];
          fn_r.dup_minus <= sa[1] & ~sa[0];
          fn_r.reverse   <= sa[3];
        end
        4'h6: begin
          fn_r.offset_edit <= sa[0] & prio_btn & ~fn_r.mem_read;
          dup600_r         <= sb[1] & sb[2];
        end
        4'h7: begin
          fn_r.prog_scan <= sa[0];
          fn_r.mem_scan  <= sa[1];
          fn_r.mem_write <= sa[3];
        end
        4'h8: fn_r.power_on <= sa[0];
        default: fn_r.power_on <= fn_r.power_on;
      endcase
    end
  end

  // ****************
  // Frequency storage
  // ****************
  logic [FW-1:0] vfo_a_r;
  logic [FW-1:0] vfo_b_r;
  logic [FW-1:0] offset_r;
  logic [FW-1:0] mem_r [NUM_MEM];
  logic [2:0]    scan_idx_r;
  logic          mem_write_d_r;
  logic          scan_btn_d_r;
  logic          sw_scan_r;
  logic [FW-1:0] lo;
  logic [FW-1:0] hi;
  logic [FW-1:0] st;
  logic          run;
  logic          step_now;
  logic          up;
  logic          prog_ok;

  assign run      = state_r == ST_RUN && fn_r.power_on;
  assign step_now = consume && a0_eff && run;
  assign up       = a1_eff;
  assign st       = FW'(fn_r.step);
  assign prog_ok  = mem_r[1] > mem_r[0];
  // Programmed scan runs between channels one and two only
  assign lo = (scan_active_r && fn_r.prog_scan) ? mem_r[0] :
              (fn_r.band_wide ? F_WIDE_LO : F_NAR_LO);
  assign hi = (scan_active_r && fn_r.prog_scan) ? mem_r[1] :
              (fn_r.band_wide ? F_WIDE_HI : F_NAR_HI);

  function automatic logic [FW-1:0] stepf(input logic [FW-1:0] f, input logic u,
                                          input logic [FW-1:0] s, input logic [FW-1:0] l,
                                          input logic [FW-1:0] h);
    if (u) begin
      stepf = (f + s > h) ? l : f + s;
    end else begin
      stepf = (f < l + s) ? h : f - s;
    end
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_WAIT_MODE;
    end else begin
      case (state_r)
        // One full pass reads the mode straps first
        ST_WAIT_MODE: if (consume && fn_r.power_on) state_r <= ST_PRESET;
        ST_PRESET:    state_r <= ST_RUN;
        default:      state_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_active_r <= 1'b0;
      scan_btn_d_r  <= 1'b0;
    end else begin
      scan_btn_d_r <= scan_btn;
      if (!run || (fn_r.prog_scan && !fn_r.mem_scan && !prog_ok)) begin
        scan_active_r <= 1'b0;
      end else if ((scan_btn && !scan_btn_d_r) || sw_scan_r) begin
        scan_active_r <= ~scan_active_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vfo_a_r       <= F_NAR_LO;
      vfo_b_r       <= F_NAR_LO;
      offset_r      <= 15'h0000;
      scan_idx_r    <= 3'h0;
      mem_write_d_r <= 1'b0;
      for (int i = 0; i < NUM_MEM; i++) mem_r[i] <= F_NAR_LO;
    end else if (state_r == ST_PRESET) begin
      vfo_a_r    <= lo;
      vfo_b_r    <= lo;
      offset_r   <= dup600_r ? OFFSET_600 : 15'h0000;
      scan_idx_r <= 3'h0;
      for (int i = 0; i < NUM_MEM; i++) mem_r[i] <= lo;
    end else if (run) begin
      mem_write_d_r <= fn_r.mem_write;
      if (fn_r.mem_write && !mem_write_d_r) begin
        if (fn_r.mem_read && fn_r.chan != 3'h0) begin
          mem_r[fn_r.chan - 3'h1] <= vfo_a_r;
        end else if (fn_r.vfo_b) begin
          vfo_b_r <= vfo_a_r;
        end else begin
          vfo_a_r <= vfo_b_r;
        end
      end else if (step_now) begin
        if (fn_r.offset_edit) begin
          offset_r <= up ? offset_r + st : (offset_r < st ? 15'h0000 : offset_r - st);
        end else if (scan_active_r && fn_r.mem_scan) begin
          // Seven stops: both VFOs then the five channels
          scan_idx_r <= (scan_idx_r == 3'h6) ? 3'h0 : scan_idx_r + 3'h1;
        end else if (fn_r.mem_read && !scan_active_r) begin
          scan_idx_r <= scan_idx_r;
        end else if (fn_r.vfo_b) begin
          vfo_b_r <= stepf(vfo_b_r, up, st, lo, hi);
        end else begin
          vfo_a_r <= stepf(vfo_a_r, up, st, lo, hi);
        end
      end
    end
  end

  // ****************
  // Receive and transmit frequency
  // ****************
  logic [FW-1:0] rx0;
  logic [FW-1:0] shifted;
  logic          dup;
  logic          in_band;
  logic [FW-1:0] rx_r;
  logic [FW-1:0] tx_r;

  always_comb begin
    if (scan_active_r && fn_r.mem_scan) begin
      rx0 = (scan_idx_r == 3'h0) ? vfo_a_r :
            (scan_idx_r == 3'h1) ? vfo_b_r : mem_r[scan_idx_r - 3'h2];
    end else if (fn_r.mem_read && fn_r.chan != 3'h0) begin
      rx0 = mem_r[fn_r.chan - 3'h1];
    end else begin
      rx0 = fn_r.vfo_b ? vfo_b_r : vfo_a_r;
    end
    shifted = fn_r.dup_plus ? rx0 + offset_r : rx0 - offset_r;
    dup     = fn_r.dup_plus | fn_r.dup_minus;
    in_band = shifted >= (fn_r.band_wide ? F_WIDE_LO : F_NAR_LO) &&
              shifted <= (fn_r.band_wide ? F_WIDE_HI : F_NAR_HI);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_r <= F_NAR_LO;
      tx_r <= F_NAR_LO;
    end else if (dup && in_band) begin
      rx_r <= fn_r.reverse ? shifted : rx0;
      tx_r <= fn_r.reverse ? rx0 : shifted;
    end else begin
      rx_r <= rx0;
      tx_r <= rx0;
    end
  end

  // ****************
  // Display and divider output
  // ****************
  function automatic logic [15:0] to_bcd(input logic [13:0] v);
    logic [29:0] sh;
    sh = {16'h0000, v};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14 + 4*d +: 4] > 4'h4) sh[14 + 4*d +: 4] = sh[14 + 4*d +: 4] + 4'h3;
      end
      sh = {sh[28:0], 1'b0};
    end
    to_bcd = sh[29:14];
  endfunction

  logic [2:0]    pos_r;
  logic [5:0]    pcnt_r;
  logic [FW-1:0] rel_d;
  logic [FW-1:0] rel_s;
  logic [15:0]   disp_bcd;
  logic [15:0]   n_bcd;
  assign rel_d    = rx_r - F_BASE;
  assign rel_s    = (ptt ? tx_r : rx_r) - F_BASE;
  // Display counts kHz above 140 MHz; shows MHz units and three below
  assign disp_bcd = to_bcd(14'(rel_d * 15'h0005));
  assign n_bcd    = to_bcd({4'h0, rel_s[10:1] + N_BIAS});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r              <= 3'h0;
      pcnt_r             <= 6'h00;
      bcd_out            <= 4'h0;
      digit_select       <= 4'h0;
      decimal_point      <= 1'b0;
      latch_position     <= 4'h0;
      synth_latch_strobe <= 1'b0;
    end else begin
      pcnt_r <= (pcnt_r == 6'(DIGIT_DWELL_CYC - 1)) ? 6'h00 : pcnt_r + 6'h01;
      if (pcnt_r == 6'(DIGIT_DWELL_CYC - 1)) pos_r <= pos_r + 3'h1;
      synth_latch_strobe <= 1'b0;
      if (!pos_r[2]) begin
        // Blank in standby; point only on the MHz digit
        digit_select   <= run ? 4'h8 >> pos_r[1:0] : 4'h0;
        bcd_out        <= disp_bcd[4*(3 - pos_r[1:0]) +: 4];
        decimal_point  <= run && pos_r[1:0] == 2'h0 && !blink_r;
        latch_position <= 4'h0;
      end else begin
        // Same BCD lines now carry divide number then 5 kHz shift
        digit_select   <= 4'h0;
        decimal_point  <= 1'b0;
        latch_position <= 4'h8 >> pos_r[1:0];
        bcd_out        <= (pos_r[1:0] == 2'h3) ? {3'h0, rel_s[0]} :
                          n_bcd[4*(2 - pos_r[1:0]) +: 4];
        synth_latch_strobe <= run && pcnt_r == 6'(LATCH_AT_CYC);
      end
    end
  end

  // ****************
  // AXI4-Lite slave
  // ****************
  logic [1:0] ctrl_r;
  logic       aw_got_r;
  logic       w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [31:0] rd;
  logic        rd_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0;
      ctrl_r        <= CTRL_RST;
      sw_scan_r     <= 1'b0;
    end else begin
      sw_scan_r     <= 1'b0;
      s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if ({awaddr_r[7:2], 2'h0} == REG_CTRL) begin
          if (s_axi_wstrb[0]) begin
            ctrl_r    <= wdata_r[1:0];
            sw_scan_r <= wdata_r[2];
          end
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd    = 32'h0;
    rd_ok = 1'b1;
    if ({s_axi_araddr[7:2], 2'h0} == REG_CTRL) begin
      rd = {30'h0, ctrl_r};
    end else if ({s_axi_araddr[7:2], 2'h0} == REG_STATUS) begin
      rd = {24'h0, state_r, 1'b0, scan_active_r, fn_r.offset_edit, fn_r.mem_read,
            fn_r.vfo_b, fn_r.power_on};
    end else if ({s_axi_araddr[7:2], 2'h0} == REG_RXF) begin
      rd = {17'h0, rx_r};
    end else if ({s_axi_araddr[7:2], 2'h0} == REG_TXF) begin
      rd = {17'h0, tx_r};
    end else if ({s_axi_araddr[7:2], 2'h0} == REG_OFFSET) begin
      rd = {17'h0, offset_r};
    end else if ({s_axi_araddr[7:2], 2'h0} == REG_MODE) begin
      rd = {21'h0, fn_r.band_wide, fn_r.step, fn_r.chan, fn_r.dup_plus,
            fn_r.dup_minus, fn_r.reverse, 1'b0};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** dv/pmc_chk_sva.sv ***
// Concurrent checks on the panel matrix controller outputs
`timescale 1ns/10ps
`default_nettype none
module pmc_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Watched outputs
  input wire logic [8:0]  strobe,
  input wire logic [3:0]  digit_select,
  input wire logic        decimal_point,
  input wire logic [3:0]  latch_position,
  input wire logic        synth_latch_strobe,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ****************
  // Properties
  // ****************
  logic [8:0] strobe_r;
  always_ff @(posedge aclk) strobe_r <= strobe;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_strobe_onehot: assert property ($onehot(strobe))
    else $error("strobe not one-hot");
  a_strobe_hold: assert property ($changed(strobe) |=> $stable(strobe) [*8])
    else $error("strobe slot too short");
  a_strobe_order: assert property (
    $changed(strobe) |-> strobe == {strobe_r[7:0], strobe_r[8]})
    else $error("strobe out of order");
  a_point_mhz: assert property (decimal_point |-> digit_select == 4'h8)
    else $error("point off the MHz digit");
  a_digit_onehot: assert property ($onehot0(digit_select))
    else $error("digit select not one-hot");
  a_latch_onehot: assert property (synth_latch_strobe |-> $onehot(latch_position))
    else $error("latch position bad");
  a_latch_gap: assert property (synth_latch_strobe |=> (!synth_latch_strobe) [*8])
    else $error("latch pulse too long");
  a_latch_slot: assert property (synth_latch_strobe |-> digit_select == 4'h0)
    else $error("latch in display slot");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  c_power: cover property (strobe[8] && |digit_select);
  c_latch: cover property (synth_latch_strobe && latch_position == 4'h1);
  c_point: cover property (decimal_point);
endmodule
bind pmc_top pmc_chk i_pmc_chk (.*);
`default_nettype wire

// *** dv/pmc_panel.sv ***
// Front panel switch matrix seen by the controller
`timescale 1ns/10ps
`default_nettype none
module pmc_panel (
  // Strobes and closed switches per strobe
  input wire logic [8:0]      strobe,
  input wire logic [8:0][3:0] sw_a,
  input wire logic [8:0][3:0] sw_b,
  // Returns
  output logic [3:0]          sense_a,
  output logic [3:0]          sense_b
);
  // ****************
  // Matrix
  // ****************
  // Diode matrix with pull-downs: an unstrobed row returns low
  always_comb begin
    sense_a = 4'h0;
    sense_b = 4'h0;
    for (int k = 0; k < 9; k++) begin
      if (strobe[k]) begin
        sense_a = sense_a | sw_a[k];
        sense_b = sense_b | sw_b[k];
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the panel matrix controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmc_pkg::*;
  // ****************
  // Signals
  // ****************
  logic            aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]      s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]      s_axi_wstrb = 4'hF;
  logic            s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic            s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]      s_axi_bresp, s_axi_rresp, r;
  logic            enc_phase_a = 1'h0, enc_phase_b = 1'h0;
  logic            scan_button_n = 1'h1, priority_button_n = 1'h1, ptt_n = 1'h1;
  logic [3:0]      sense_a, sense_b, bcd_out, digit_select, latch_position;
  logic [8:0]      strobe;
  logic            decimal_point, synth_latch_strobe;
  // Power on, narrow band, 600 kHz preset
  logic [8:0][3:0] sw_a = 36'h100000000, sw_b = 36'h006000004;
  int              n_errors = 0, tests_run = 0;

  pmc_top #(.SCAN_PERIOD(50)) i_pmc_top (.*);
  pmc_panel i_pmc_panel (.*);
  always #12.5 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic t_power;
    repeat (600) @(posedge aclk);
    rd(REG_STATUS);
    chk("power", 32'h1, d[0]);
    chk("state", ST_RUN, d[7:6]);
    rd(REG_OFFSET);
    chk("offset", OFFSET_600, d);
    rd(REG_RXF);
    chk("rx", F_NAR_LO, d);
    wr(REG_RXF, 32'h0);
    chk("ro write", RESP_SLVERR, r);
    rd(8'h18);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {r, d});
  endtask
  task automatic t_modes;
    logic [3:0]    st_sw [4] = '{4'h4, 4'h8, 4'h5, 4'h9};
    logic [2:0]    st_x [4] = '{STEP_5K, STEP_10K, STEP_15K, STEP_25K};
    logic [3:0]    dp_sw [3] = '{4'h1, 4'h2, 4'h9};
    logic [2:0]    dp_x [3] = '{3'h4, 3'h2, 3'h5};
    logic [FW-1:0] up;
    up = F_NAR_LO + OFFSET_600;
    for (int i = 0; i < 5; i++) begin
      sw_a[2] <= (i < 4) ? 4'h1 << i : 4'h3;
      sw_a[4] <= st_sw[i % 4];
      sw_a[5] <= dp_sw[i % 3];
      repeat (300) @(posedge aclk);
      rd(REG_MODE);
      chk("chan", i + 1, d[6:4]);
      chk("step", st_x[i % 4], d[9:7]);
      chk("duplex", dp_x[i % 3], d[3:1]);
      rd(REG_RXF);
      chk("rx", (i % 3 == 2) ? up : F_NAR_LO, d);
      rd(REG_TXF);
      // Minus offset leaves the band, so transmit stays on receive
      chk("tx", (i % 3 == 0) ? up : F_NAR_LO, d);
    end
    sw_a[5] <= 4'h0;
  endtask
  task automatic t_out;
    int f, n;
    int x [8];
    f = F_NAR_LO * 5;
    n = (F_NAR_LO - F_BASE) / 2 + N_BIAS;
    x = '{f / 1000 % 10, f / 100 % 10, f / 10 % 10, f % 10,
          n / 100, n / 10 % 10, n % 10, (F_NAR_LO - F_BASE) % 2};
    for (int i = 0; i < 8; i++) begin
      @(negedge aclk);
      while (i < 4 ? digit_select !== 4'h8 >> i : (synth_latch_strobe !== 1'h1 ||
             latch_position !== 4'h8 >> (i - 4))) @(negedge aclk);
      chk("digit", x[i], bcd_out);
      if (i < 4) chk("point", i == 0, decimal_point);
    end
    @(posedge aclk);
  endtask
  task automatic enc(input logic up);
    enc_phase_b <= up;
    repeat (8) @(posedge aclk);
    enc_phase_a <= 1'h1;
    repeat (8) @(posedge aclk);
    enc_phase_b <= ~up;
    repeat (8) @(posedge aclk);
    enc_phase_a <= 1'h0;
    repeat (8) @(posedge aclk);
    enc_phase_b <= 1'h0;
    repeat (300) @(posedge aclk);
    rd(REG_RXF);
  endtask
  task automatic t_tune;
    sw_a[4] <= 4'h4;
    repeat (300) @(posedge aclk);
    enc(1'h1);
    chk("tune up", F_NAR_LO + STEP_5K, d);
    enc(1'h0);
    chk("tune down", F_NAR_LO, d);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    chk("strobe reset", 9'h001, strobe);
    aresetn <= 1'h1;
    t_power();
    t_modes();
    t_out();
    t_tune();
    results();
  end
  // Whole run is near 3500 cycles
  initial begin
    repeat (12000) @(posedge aclk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
